// >>> core/crfies_pkg.sv
/*
 * Constants shared by the receive-queue, interrupt-mask and fault-status slice.
 * Assumes a word-wide register port with byte offsets as printed.
 */
package crfies_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_Q0_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_Q1_STATUS   = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
	localparam logic [7:0] OFS_FAULT       = 8'h18;
	// Queue status field positions
	localparam int BIT_Q_RELEASE           = 5;
	localparam int BIT_Q_OVERFLOW          = 4;
	localparam int BIT_Q_FULL              = 3;
	localparam int BIT_Q_COUNT_HI          = 1;
	// Interrupt mask field positions
	localparam int BIT_TX_EMPTY_EN         = 0;
	localparam int BIT_Q0_NONEMPTY_EN      = 1;
	localparam int BIT_Q0_FULL_EN          = 2;
	localparam int BIT_Q0_OVERFLOW_EN      = 3;
	localparam int BIT_Q1_NONEMPTY_EN      = 4;
	localparam int BIT_Q1_FULL_EN          = 5;
	localparam int BIT_Q1_OVERFLOW_EN      = 6;
	localparam int BIT_WARNING_EN          = 8;
	localparam int BIT_PASSIVE_EN          = 9;
	localparam int BIT_BUSOFF_EN           = 10;
	localparam int BIT_CODE_EN             = 11;
	localparam int BIT_FAULT_EN            = 15;
	localparam int BIT_WAKEUP_EN           = 16;
	localparam int BIT_SLEEP_EN            = 17;
	localparam logic [31:0] MASK_WRITABLE  = 32'h0003_8F7F;
	// Fault status field positions
	localparam int BIT_WARNING             = 0;
	localparam int BIT_PASSIVE             = 1;
	localparam int BIT_BUSOFF              = 2;
	localparam int BIT_CODE_LO             = 4;
	localparam int BIT_CODE_HI             = 6;
	localparam int BIT_TX_CNT_LO           = 16;
	localparam int BIT_RX_CNT_LO           = 24;
	// Reset values and levels
	localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
	localparam logic [1:0]  QUEUE_DEPTH    = 2'h3;
	localparam logic [2:0]  CODE_NONE      = 3'h0;
	localparam logic [7:0]  WARNING_LEVEL  = 8'h60;
	localparam logic [7:0]  PASSIVE_LEVEL  = 8'h7F;
	localparam logic [8:0]  COUNTER_TOP    = 9'h0FF;
endpackage

// >>> core/crfies_q_if.sv
/*
 * Carrier between the top and one receive-queue status tracker.
 * Assumes the top drives the request side and the tracker answers.
 */
`timescale 1ns/1ns
interface crfies_q_if;
	logic       push;        // Engine stores a frame, one-cycle pulse
	logic       releaseSet;  // Software wrote 1 to the release bit
	logic       fullClr;     // Software wrote 1 to the full flag
	logic       overClr;     // Software wrote 1 to the overflow flag
	logic [1:0] count;       // Frames pending
	logic       full;        // Sticky full flag
	logic       overflow;    // Sticky overflow flag
	logic       relBit;      // Release bit as read back
	logic       pop;         // Oldest frame removed, one-cycle pulse

	// Top side
	modport ctrl (
		output push, releaseSet, fullClr, overClr,
		input  count, full, overflow, relBit, pop
	);
	// Tracker side
	modport queue (
		input  push, releaseSet, fullClr, overClr,
		output count, full, overflow, relBit, pop
	);
endinterface

// >>> core/crfies_queue.sv
/*
 * Fill level, full, overflow and release handling for one receive queue.
 * Assumes software and engine events arrive as one-cycle pulses on mclk.
 */
`timescale 1ns/1ns
module crfies_queue
	import crfies_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Queue carrier
	crfies_q_if.queue q
);
	logic       doPop;      // Release completes this cycle with a frame present
	logic       accept;     // Arriving frame finds a slot
	logic [1:0] next_count; // Fill level after this cycle

	// A pop frees a slot in the same cycle, so a push onto a full queue then still fits
	assign doPop  = q.relBit && (q.count != 2'h0);
	assign accept = q.push && ((q.count != QUEUE_DEPTH) || doPop);

	always_comb begin
		next_count = q.count;
		if (accept && !doPop) begin
			next_count = q.count + 2'h1;
		end else if (!accept && doPop) begin
			next_count = q.count - 2'h1;
		end
	end

	// Fill level and pop strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q.count <= 2'h0;
			q.pop   <= 1'b0;
		end else begin
			q.count <= next_count;
			q.pop   <= doPop;
		end
	end

	// Release bit: set by software, dropped by hardware one cycle later once done
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q.relBit <= 1'b0;
		end else if (q.releaseSet) begin
			q.relBit <= 1'b1;
		end else if (q.relBit) begin
			q.relBit <= 1'b0;
		end
	end

	// Sticky flags; a hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q.full     <= 1'b0;
			q.overflow <= 1'b0;
		end else begin
			if (accept && (next_count == QUEUE_DEPTH)) begin
				q.full <= 1'b1;
			end else if (q.fullClr) begin
				q.full <= 1'b0;
			end
			if (q.push && !accept) begin
				q.overflow <= 1'b1;
			end else if (q.overClr) begin
				q.overflow <= 1'b0;
			end
		end
	end
endmodule // crfies_queue

// >>> core/crfies_top.sv
/*
 * Status slice of a bus controller: two receive queues, the interrupt mask
 * and the fault status with its counters.
 * Assumes the protocol engine signals frame arrival, fault codes and counter
 * steps as one-cycle pulses on mclk, and software uses whole-word accesses.
 * Reads and writes are one-cycle strobes with no wait states.
 * Read data holds until the next read.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - Write 1 releases oldest queue 0 frame
// - Queue 0 overflow flag, clear by 1
// - Queue 0 full flag, clear by 1
// - Queue 0 pending count, read only
// - Write 1 releases oldest queue 1 frame
// - Queue 1 overflow flag, clear by 1
// - Queue 1 full flag, clear by 1
// - Queue 1 pending count, read only
// - Queue 1 overflow, full, nonempty enables
// - Queue 0 overflow, full, nonempty enables
// - Transmit slot empty interrupt enable
// - Fault, code, busoff, passive, warning enables
// - Wakeup and sleep entry enables
// - Receive and transmit fault counters shown
// - Last fault code field, eight codes
// - Success clears code; software may write
// - Transmit counter overflow enters busoff
// - Passive when either counter above 127
// - Warning when either counter at least 96
module crfies_top
	import crfies_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,

	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [31:0] regWdata,
	output logic      [31:0] regRdata,

	// Receive queue events from the engine
	input  wire logic        q0Push,
	input  wire logic        q1Push,
	output logic             q0Pop,
	output logic             q1Pop,

	// Fault events from the engine
	// Up wins over down in one cycle
	input  wire logic        faultCodeValid,
	input  wire logic [2:0]  faultCode,
	input  wire logic        transferOk,
	input  wire logic        txFaultUp,
	input  wire logic        txFaultDown,
	input  wire logic [3:0]  txFaultStep,
	input  wire logic        rxFaultUp,
	input  wire logic        rxFaultDown,
	input  wire logic [3:0]  rxFaultStep,
	input  wire logic        busoffRecover,
	output logic             busoffState,

	// Other interrupt sources
	input  wire logic        txSlotEmpty,
	input  wire logic        wakeupEvent,
	input  wire logic        sleepEvent,

	// Interrupt output
	output logic             irq
);
	// Queue carriers, one per receive queue
	crfies_q_if qBus [2] ();

	// Stored registers
	logic [31:0] irqMask;          // Interrupt enable word
	logic [7:0]  txFaultCounter;   // Transmit fault counter
	logic [7:0]  rxFaultCounter;   // Receive fault counter
	logic [2:0]  lastFaultCode;    // Last fault code field
	logic        busoffFlag;       // Busoff status bit
	logic        passiveFlag;      // Passive status bit
	logic        warningFlag;      // Warning status bit

	// Write strobes
	logic        wrQ0;             // Write strobe, queue 0 status
	logic        wrQ1;             // Write strobe, queue 1 status
	logic        wrMask;           // Write strobe, interrupt mask
	logic        wrFault;          // Write strobe, fault status

	// Counter arithmetic
	logic [8:0]  txSum;            // Transmit counter with carry room
	logic [8:0]  rxSum;            // Receive counter with carry room
	logic [7:0]  next_txCounter;   // Transmit counter after this cycle
	logic [7:0]  next_rxCounter;   // Receive counter after this cycle
	logic        txOverflow;       // Transmit counter passes its top

	// Interrupt and read paths
	logic        faultGroup;       // Any enabled fault condition
	logic        queueGroup;       // Any enabled queue condition
	logic        next_irq;         // Interrupt level before its flop
	logic [31:0] next_rdata;       // Read word before its flop

	// Address decode; leaves byte lanes out since every access is a word
	// An unmapped offset matches no branch, so the write is dropped
	always_comb begin
		wrQ0    = 1'b0;
		wrQ1    = 1'b0;
		wrMask  = 1'b0;
		wrFault = 1'b0;
		if (regWrite && (regAddr == OFS_Q0_STATUS)) begin
			// Queue 0 status
			wrQ0 = 1'b1;
		end else if (regWrite && (regAddr == OFS_Q1_STATUS)) begin
			// Queue 1 status
			wrQ1 = 1'b1;
		end else if (regWrite && (regAddr == OFS_IRQ_MASK)) begin
			// Interrupt mask
			wrMask = 1'b1;
		end else if (regWrite && (regAddr == OFS_FAULT)) begin
			// Fault status
			wrFault = 1'b1;
		end
	end

	// Software requests into each queue tracker
	// Writing 0 to a flag bit leaves the flag alone
	// Push comes straight from the engine
	assign qBus[0].push       = q0Push;
	assign qBus[0].releaseSet = wrQ0 && regWdata[BIT_Q_RELEASE];
	assign qBus[0].fullClr    = wrQ0 && regWdata[BIT_Q_FULL];
	assign qBus[0].overClr    = wrQ0 && regWdata[BIT_Q_OVERFLOW];
	assign qBus[1].push       = q1Push;
	assign qBus[1].releaseSet = wrQ1 && regWdata[BIT_Q_RELEASE];
	assign qBus[1].fullClr    = wrQ1 && regWdata[BIT_Q_FULL];
	assign qBus[1].overClr    = wrQ1 && regWdata[BIT_Q_OVERFLOW];

	// One tracker per receive queue
	// Both queues share one design, so their timing matches
	// gi picks the carrier of each tracker
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gQueue
			crfies_queue uQueue (
				.mclk (mclk),
				.rst  (rst),
				.q    (qBus[gi])
			);
		end
	endgenerate

	// Pop strobes to the engine, kept on flops so the outputs stay registered
	// The flop adds one cycle to the tracker's pop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q0Pop <= 1'b0;
			q1Pop <= 1'b0;
		end else begin
			// A pulse per completed release
			q0Pop <= qBus[0].pop;
			q1Pop <= qBus[1].pop;
		end
	end

	// Interrupt mask; reserved bits never store
	// Bits 7, 12 to 14 and 18 up read back as zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irqMask <= RESET_WORD;
		end else if (wrMask) begin
			// Whole word replaces the stored enables
			irqMask <= regWdata & MASK_WRITABLE;
		end
	end

	// Counter arithmetic; the sums carry one extra bit so a pass of the top is seen
	// Down never wraps below zero; up wins a tie
	always_comb begin
		txSum = {1'b0, txFaultCounter};
		rxSum = {1'b0, rxFaultCounter};
		if (txFaultUp) begin
			// Transmit step up
			txSum = {1'b0, txFaultCounter} + {5'h00, txFaultStep};
		end else if (txFaultDown && (txFaultCounter != 8'h00)) begin
			// Transmit step down
			txSum = {1'b0, txFaultCounter} - 9'h001;
		end
		if (rxFaultUp) begin
			// Receive step up
			rxSum = {1'b0, rxFaultCounter} + {5'h00, rxFaultStep};
		end else if (rxFaultDown && (rxFaultCounter != 8'h00)) begin
			// Receive step down
			rxSum = {1'b0, rxFaultCounter} - 9'h001;
		end
	end

	// Saturate at the top; a transmit pass is what takes the node off the bus
	// A receive pass only clips the counter
	assign txOverflow     = txSum > COUNTER_TOP;
	assign next_txCounter = txOverflow ? COUNTER_TOP[7:0] : txSum[7:0];
	assign next_rxCounter = (rxSum > COUNTER_TOP) ? COUNTER_TOP[7:0] : rxSum[7:0];

	// Fault counters; recovery from busoff restarts both from zero
	// Recovery beats a step in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txFaultCounter <= 8'h00;
			rxFaultCounter <= 8'h00;
		end else if (busoffRecover) begin
			// Back to error active
			txFaultCounter <= 8'h00;
			rxFaultCounter <= 8'h00;
		end else begin
			txFaultCounter <= next_txCounter;
			rxFaultCounter <= next_rxCounter;
		end
	end

	// Busoff state; held until the engine reports recovery
	// Recovery wins a tie with a new overflow
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busoffFlag <= 1'b0;
		end else if (txOverflow && !busoffRecover) begin
			busoffFlag <= 1'b1;
		end else if (busoffRecover) begin
			// Only recovery clears it
			busoffFlag <= 1'b0;
		end
	end

	// Level flags follow the counters one cycle behind them
	// The lag keeps the compares off the adder path
	// Either counter can raise either flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			passiveFlag <= 1'b0;
			warningFlag <= 1'b0;
		end else begin
			passiveFlag <= (txFaultCounter > PASSIVE_LEVEL) || (rxFaultCounter > PASSIVE_LEVEL);
			warningFlag <= (txFaultCounter >= WARNING_LEVEL) || (rxFaultCounter >= WARNING_LEVEL);
		end
	end

	// Last fault code; a hardware update beats a software write in the same cycle
	// Order: engine code, then success, then software
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lastFaultCode <= CODE_NONE;
		end else if (faultCodeValid) begin
			lastFaultCode <= faultCode;
		end else if (transferOk) begin
			lastFaultCode <= CODE_NONE;
		end else if (wrFault) begin
			// Writing all ones lets software spot the next hardware update
			lastFaultCode <= regWdata[BIT_CODE_HI:BIT_CODE_LO];
		end
	end

	// Busoff level to the engine from a flop
	// The engine sees it one cycle after the flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busoffState <= 1'b0;
		end else begin
			// Registered copy
			busoffState <= busoffFlag;
		end
	end

	// Enabled fault conditions, gated as a group by the general fault enable
	// Code change is taken as any nonzero code
	assign faultGroup = irqMask[BIT_FAULT_EN] && (
		(warningFlag && irqMask[BIT_WARNING_EN]) ||
		(passiveFlag && irqMask[BIT_PASSIVE_EN]) ||
		(busoffFlag  && irqMask[BIT_BUSOFF_EN])  ||
		((lastFaultCode != CODE_NONE) && irqMask[BIT_CODE_EN]));

	// Enabled queue conditions
	// Nonempty is live; full and overflow are sticky
	assign queueGroup =
		((qBus[0].count != 2'h0) && irqMask[BIT_Q0_NONEMPTY_EN]) ||
		(qBus[0].full            && irqMask[BIT_Q0_FULL_EN])     ||
		(qBus[0].overflow        && irqMask[BIT_Q0_OVERFLOW_EN]) ||
		((qBus[1].count != 2'h0) && irqMask[BIT_Q1_NONEMPTY_EN]) ||
		(qBus[1].full            && irqMask[BIT_Q1_FULL_EN])     ||
		(qBus[1].overflow        && irqMask[BIT_Q1_OVERFLOW_EN]);

	// Interrupt level; sources are levels, so it falls when the cause is cleared
	// Transmit, wakeup and sleep come in as levels
	assign next_irq = faultGroup || queueGroup ||
		(txSlotEmpty && irqMask[BIT_TX_EMPTY_EN]) ||
		(wakeupEvent && irqMask[BIT_WAKEUP_EN])   ||
		(sleepEvent  && irqMask[BIT_SLEEP_EN]);

	// Interrupt flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			// One cycle behind its sources
			irq <= next_irq;
		end
	end

	// Read word selection; unmapped offsets and reserved bits read as zero
	// Every field is built on zero, never on stale state
	always_comb begin
		next_rdata = RESET_WORD;
		if (regAddr == OFS_Q0_STATUS) begin
			// Queue 0 status
			next_rdata[BIT_Q_RELEASE]          = qBus[0].relBit;
			next_rdata[BIT_Q_OVERFLOW]         = qBus[0].overflow;
			next_rdata[BIT_Q_FULL]             = qBus[0].full;
			next_rdata[BIT_Q_COUNT_HI:0]       = qBus[0].count;
		end else if (regAddr == OFS_Q1_STATUS) begin
			// Queue 1 status
			next_rdata[BIT_Q_RELEASE]          = qBus[1].relBit;
			next_rdata[BIT_Q_OVERFLOW]         = qBus[1].overflow;
			next_rdata[BIT_Q_FULL]             = qBus[1].full;
			next_rdata[BIT_Q_COUNT_HI:0]       = qBus[1].count;
		end else if (regAddr == OFS_IRQ_MASK) begin
			// Enables as stored
			next_rdata                         = irqMask;
		end else if (regAddr == OFS_FAULT) begin
			// Counters, code and flags
			next_rdata[BIT_RX_CNT_LO +: 8]     = rxFaultCounter;
			next_rdata[BIT_TX_CNT_LO +: 8]     = txFaultCounter;
			next_rdata[BIT_CODE_HI:BIT_CODE_LO] = lastFaultCode;
			next_rdata[BIT_BUSOFF]             = busoffFlag;
			next_rdata[BIT_PASSIVE]            = passiveFlag;
			next_rdata[BIT_WARNING]            = warningFlag;
		end
	end

	// Read data register; updated only on a read so the port holds between reads
	// A write never disturbs the read port
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			regRdata <= RESET_WORD;
		end else if (regRead) begin
			// Capture the selected word
			regRdata <= next_rdata;
		end
	end
endmodule // crfies_top

// >>> tb/crfies_assertions.sv
/*
 * Concurrent checks on the status slice, seen from the top ports.
 * Assumes it is bound to crfies_top in the bench.
 */
`timescale 1ns/1ns
module crfies_assertions
	import crfies_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  regAddr,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [31:0] regWdata,
	input wire logic [31:0] regRdata,
	// Queue and fault signals
	input wire logic        q0Pop,
	input wire logic        q1Pop,
	input wire logic        busoffRecover,
	input wire logic        busoffState,
	// Interrupt sources and output
	input wire logic        txSlotEmpty,
	input wire logic        wakeupEvent,
	input wire logic        sleepEvent,
	input wire logic        irq
);
	logic [31:0] maskShadow; // Stored mask bits as software left them
	logic        rel0;       // Release write to queue 0
	logic        rel1;       // Release write to queue 1

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	assign rel0 = regWrite && regAddr == OFS_Q0_STATUS && regWdata[BIT_Q_RELEASE];
	assign rel1 = regWrite && regAddr == OFS_Q1_STATUS && regWdata[BIT_Q_RELEASE];

	// Mask shadow, so interrupt checks know which sources are open
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			maskShadow <= RESET_WORD;
		end else if (regWrite && regAddr == OFS_IRQ_MASK) begin
			maskShadow <= regWdata & MASK_WRITABLE;
		end
	end

	a_q0_pop_cause: assert property (q0Pop |-> $past(rel0, 3)) else $error("queue 0 pop without release");
	a_q1_pop_cause: assert property (q1Pop |-> $past(rel1, 3)) else $error("queue 1 pop without release");
	a_busoff_recover: assert property (busoffRecover |-> ##2 !busoffState) else $error("busoff stays");
	a_mask_off_irq: assert property (maskShadow == 32'h0 |=> !irq) else $error("irq with empty mask");
	a_tx_empty_irq: assert property (txSlotEmpty && maskShadow[0] |=> irq) else $error("tx empty irq lost");
	a_wakeup_irq: assert property (wakeupEvent && maskShadow[16] |=> irq) else $error("wakeup irq lost");
	a_sleep_irq: assert property (sleepEvent && maskShadow[17] |=> irq) else $error("sleep irq lost");
	a_mask_readback: assert property (regRead && regAddr == OFS_IRQ_MASK
		|=> regRdata == $past(maskShadow)) else $error("mask read wrong");
	a_rdata_holds: assert property (!regRead |=> $stable(regRdata)) else $error("read data moved");
	a_fault_reserved: assert property (regRead && regAddr == OFS_FAULT
		|=> regRdata[15:7] == 9'h000 && !regRdata[3]) else $error("fault reserved set");
endmodule // crfies_assertions

// >>> tb/crfies_engine_model.sv
/*
 * Protocol engine stand-in: frame arrivals, fault codes, counter steps.
 * Assumes one-cycle pulses launched just after a rising edge of mclk.
 */
`timescale 1ns/1ns
module crfies_engine_model (
	// Clock
	input wire logic  mclk,
	// Events toward the slice
	output logic       q0Push,
	output logic       q1Push,
	output logic       faultCodeValid,
	output logic [2:0] faultCode,
	output logic       transferOk,
	output logic       txFaultUp,
	output logic       txFaultDown,
	output logic [3:0] txFaultStep,
	output logic       rxFaultUp,
	output logic       rxFaultDown,
	output logic [3:0] rxFaultStep,
	output logic       busoffRecover
);
	// Quiet at time zero
	initial begin
		{busoffRecover, rxFaultDown, txFaultDown, rxFaultUp, txFaultUp, transferOk, faultCodeValid} = 7'h00;
		{q1Push, q0Push} = 2'h0;
		{faultCode, txFaultStep, rxFaultStep} = 11'h000;
	end

	// One pulse; data lines flip afterwards so stale values never match
	task automatic send(input logic [8:0] sel, input logic [3:0] val);
		@(posedge mclk);
		#1;
		{busoffRecover, rxFaultDown, txFaultDown, rxFaultUp, txFaultUp, transferOk, faultCodeValid, q1Push, q0Push} = sel;
		faultCode = val[2:0];
		txFaultStep = val;
		rxFaultStep = val;
		@(posedge mclk);
		#1;
		{busoffRecover, rxFaultDown, txFaultDown, rxFaultUp, txFaultUp, transferOk, faultCodeValid, q1Push, q0Push} = 9'h0;
		faultCode = ~val[2:0];
		txFaultStep = ~val;
		rxFaultStep = ~val;
	endtask
endmodule // crfies_engine_model

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the status slice.
 * Assumes the engine model and the checker files are compiled first.
 */
`timescale 1ns/1ns
module tb_top
	import crfies_pkg::*;
;
	logic        mclk, rst, regWrite, regRead, irq;   // Clock, reset, strobes
	logic [7:0]  regAddr;                             // Register offset
	logic [31:0] regWdata, regRdata;                  // Register data
	logic        q0Push, q1Push, q0Pop, q1Pop;        // Queue events
	logic        faultCodeValid, transferOk, busoffRecover, busoffState;
	logic [2:0]  faultCode;                           // Engine fault code
	logic        txFaultUp, txFaultDown, rxFaultUp, rxFaultDown;
	logic [3:0]  txFaultStep, rxFaultStep;            // Counter steps
	logic        txSlotEmpty, wakeupEvent, sleepEvent; // Level sources
	int          errCount, numChecks;                 // Bench tallies

	crfies_top i_crfies_top (.mclk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .q0Push, .q1Push,
		.q0Pop, .q1Pop, .faultCodeValid, .faultCode, .transferOk, .txFaultUp, .txFaultDown, .txFaultStep,
		.rxFaultUp, .rxFaultDown, .rxFaultStep, .busoffRecover, .busoffState, .txSlotEmpty, .wakeupEvent,
		.sleepEvent, .irq);
	crfies_engine_model i_engine (.mclk, .q0Push, .q1Push, .faultCodeValid, .faultCode, .transferOk, .txFaultUp,
		.txFaultDown, .txFaultStep, .rxFaultUp, .rxFaultDown, .rxFaultStep, .busoffRecover);

	// Free-running clock, 4 ns
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Compare and tally
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts, verdict, end of run
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole-word write, held for one taking edge
	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1;
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(posedge mclk);
		#1;
		regWrite = 1'b0;
		regWdata = ~d;
	endtask

	// Whole-word read; data is registered, so take it after the edge
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		#1;
		regAddr = a;
		regRead = 1'b1;
		@(posedge mclk);
		#1;
		regRead = 1'b0;
		check(regRdata, exp);
	endtask

	// Expected fault word from counters, code and busoff
	function automatic logic [31:0] faultWord(input logic [7:0] rx, tx, input logic [2:0] c, input logic bo);
		return {rx, tx, 9'h000, c, 1'b0, bo, (rx > 8'h7F || tx > 8'h7F), (rx >= 8'h60 || tx >= 8'h60)};
	endfunction

	logic [7:0]  rx, tx;  // Model of the fault counters
	logic [8:0]  sum;     // Unclipped transmit sum
	logic [3:0]  st;      // Random step
	logic [31:0] d;       // Random word
	logic        bo;      // Expected busoff
	int          i, q;    // Loop indices
	int          bits[7] = '{0, 16, 17, 1, 4, 2, 6};
	logic        hits[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	// Hang guard
	initial begin
		#200000;
		errCount++;
		$display("BAD t=%0t run too long", $time);
		reportAndStop();
	end

	// Main sequence
	initial begin
		{rst, regWrite, regRead, regAddr, regWdata} = {3'h4, 8'h00, 32'h0};
		{txSlotEmpty, wakeupEvent, sleepEvent} = 3'h0;
		void'($urandom(32'hA0DE));
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		for (i = 0; i < 5; i++) begin
			rdChk(8'h0C + 8'(i * 4), 32'h0);
		end
		$display("test reset done");
		for (i = 0; i < 5; i++) begin
			d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			regWr(OFS_IRQ_MASK, d);
			rdChk(OFS_IRQ_MASK, d & 32'h0003_8F7F);
		end
		$display("test mask done");
		for (q = 0; q < 2; q++) begin
			repeat (3) i_engine.send(9'(q + 1), 4'h0);
			rdChk(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h0B);
			i_engine.send(9'(q + 1), 4'h0);
			rdChk(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h1B);
			regWr(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h18);
			rdChk(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h03);
			regWr(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h20);
			for (i = 0; i < 8 && (q ? q1Pop : q0Pop) !== 1'b1; i++) begin
				@(posedge mclk);
				#1;
			end
			check(32'(i < 8), 32'h1);
			rdChk(q ? OFS_Q1_STATUS : OFS_Q0_STATUS, 32'h02);
		end
		$display("test queues done");
		{txSlotEmpty, wakeupEvent, sleepEvent} = 3'h7;
		for (i = 0; i < 7; i++) begin
			regWr(OFS_IRQ_MASK, 32'h1 << bits[i]);
			repeat (2) @(posedge mclk);
			#1;
			check(32'(irq), 32'(hits[i]));
			regWr(OFS_IRQ_MASK, 32'h0);
			repeat (2) @(posedge mclk);
			#1;
			check(32'(irq), 32'h0);
		end
		{txSlotEmpty, wakeupEvent, sleepEvent} = 3'h0;
		$display("test interrupts done");
		for (i = 1; i < 8; i++) begin
			i_engine.send(9'h004, 4'(i));
			rdChk(OFS_FAULT, faultWord(8'h0, 8'h0, 3'(i), 1'b0));
		end
		i_engine.send(9'h008, 4'h0);
		rdChk(OFS_FAULT, faultWord(8'h0, 8'h0, 3'h0, 1'b0));
		regWr(OFS_FAULT, 32'hFFFF_FF7F);
		rdChk(OFS_FAULT, faultWord(8'h0, 8'h0, 3'h7, 1'b0));
		{rx, tx, bo} = 17'h0;
		while (rx < 8'h82) begin
			st = 4'($urandom_range(15, 1));
			i_engine.send(9'h020, st);
			rx = rx + {4'h0, st};
			rdChk(OFS_FAULT, faultWord(rx, tx, 3'h7, bo));
		end
		i_engine.send(9'h080, 4'h0);
		rx = rx - 8'h01;
		rdChk(OFS_FAULT, faultWord(rx, tx, 3'h7, bo));
		repeat (18) begin
			i_engine.send(9'h010, 4'hF);
			sum = {1'b0, tx} + 9'h00F;
			bo = bo | (sum > 9'h0FF);
			tx = (sum > 9'h0FF) ? 8'hFF : sum[7:0];
			rdChk(OFS_FAULT, faultWord(rx, tx, 3'h7, bo));
		end
		check(32'(busoffState), 32'h1);
		i_engine.send(9'h040, 4'h0);
		tx = tx - 8'h01;
		rdChk(OFS_FAULT, faultWord(rx, tx, 3'h7, bo));
		regWr(OFS_IRQ_MASK, 32'h8400);
		repeat (2) @(posedge mclk);
		#1;
		check(32'(irq), 32'h1);
		regWr(OFS_IRQ_MASK, 32'h0400);
		repeat (2) @(posedge mclk);
		#1;
		check(32'(irq), 32'h0);
		i_engine.send(9'h100, 4'h0);
		rdChk(OFS_FAULT, faultWord(8'h0, 8'h0, 3'h7, 1'b0));
		check(32'(busoffState), 32'h0);
		$display("test faults done");
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		rdChk(OFS_Q0_STATUS, 32'h0);
		rdChk(OFS_IRQ_MASK, 32'h0);
		$display("test second reset done");
		reportAndStop();
	end
endmodule // tb_top

bind crfies_top crfies_assertions i_crfies_assertions (.mclk, .rst, .regAddr, .regWrite, .regRead, .regWdata,
	.regRdata, .q0Pop, .q1Pop, .busoffRecover, .busoffState, .txSlotEmpty, .wakeupEvent, .sleepEvent, .irq);
